/* rtl/pwr_wake_defines.svh */
// constants for the power and wake control register and its timing
`ifndef PWR_WAKE_DEFINES_SVH
`define PWR_WAKE_DEFINES_SVH
`define OFS_POWER_WAKE_CONTROL 8'h84
`define OFS_BYTE_TEST 8'h64
`define OFS_HW_CONFIG 8'h74
`define BIT_STATE_HI 13
`define BIT_STATE_LO 12
`define BIT_XCVR_RST 10
`define BIT_WAKE_FRAME_EN 9
`define BIT_ENERGY_EN 8
`define BIT_DRIVER_TYPE 6
`define BIT_CAUSE_HI 5
`define BIT_CAUSE_LO 4
`define BIT_PULSE_SEL 3
`define BIT_POLARITY 2
`define BIT_OUT_EN 1
`define BIT_READY 0
`define CLK_HZ 25000000
`define XCVR_RST_US 100
// scaled per microsecond first, so the product stays inside a 32-bit integer
`define XCVR_RST_CYCLES (`XCVR_RST_US * (`CLK_HZ / 1000000))
`define WAKE_PULSE_MS 50
`define WAKE_PULSE_CYCLES (`WAKE_PULSE_MS * (`CLK_HZ / 1000))
`define READY_SETTLE_CYCLES 16
`endif

/* rtl/pwr_wake_pkg.sv */
// types shared by both ends of the power and wake control link
`default_nettype none
package pwr_wake_pkg;
   typedef enum logic [1:0] {
      full_power_state = 2'h0,
      wake_frame_sleep_state = 2'h1,
      energy_detect_sleep_state = 2'h2,
      reserved_state = 2'h3
   } power_state_t;
endpackage
`default_nettype wire

/* rtl/pwr_wake_if.sv */
// register port and wake pins between host and device
`timescale 1ns/1ps
`default_nettype none
interface pwr_wake_if;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic wr;
   logic rd;
   logic wake_output_o;
   logic wake_output_oe;
   logic wake_interrupt;
   modport device (input addr, wdata, wr, rd,
      output rdata, wake_output_o, wake_output_oe, wake_interrupt);
   modport host (output addr, wdata, wr, rd,
      input rdata, wake_output_o, wake_output_oe, wake_interrupt);
endinterface
`default_nettype wire

/* rtl/pwr_wake_device.sv */
// device end: power state, transceiver reset, wake sources and wake output pin
// How it works
// [RULE_01] host reads once before writes take effect
// [RULE_02] control register readable in every power state
// [RULE_03] two-bit field selects full or sleep states
// [RULE_04] state field clears itself on wake
// [RULE_05] byte test write wakes sleeping device
// [RULE_06] only wake register written while not ready
// [RULE_07] transceiver reset held at least 100us, self-clears
// [RULE_08] reset bit writes ignored while set
// [RULE_09] wake frame event drives output and interrupt
// [RULE_10] energy event drives output and interrupt
// [RULE_11] driver type: open drain low or push-pull
// [RULE_12] cause field encodes energy, frame, multiple
// [RULE_13] cause bits clear by one, when ready
// [RULE_14] pulse 50ms or hold static
// [RULE_15] clearing cause or enable drops output
// [RULE_16] push-pull polarity selects active level
// [RULE_17] output enable gates pin, not interrupt
// [RULE_18] ready low until settled after power-up or wake
// [RULE_19] only config and control read while not ready
`timescale 1ns/1ps
`default_nettype none
`include "pwr_wake_defines.svh"
module pwr_wake_device
   import pwr_wake_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // register port
   pwr_wake_if.device bus,
   // event sources, from pins or other clocks
   input wire logic wake_frame_event,
   input wire logic energy_event,
   // transceiver reset and state
   output logic transceiver_reset,
   output logic [1:0] power_state_select
);
   localparam int RST_W = 16;
   localparam int PULSE_W = 21;
   localparam logic [RST_W-1:0] RST_LAST = RST_W'(`XCVR_RST_CYCLES - 1);
   localparam logic [PULSE_W-1:0] PULSE_LAST = PULSE_W'(`WAKE_PULSE_CYCLES - 1);
   localparam logic [4:0] SETTLE_LAST = 5'(`READY_SETTLE_CYCLES - 1);

   // ----------------------------------------
   // synchronisers
   // ----------------------------------------
   logic [1:0] frame_sync;
   logic [1:0] energy_sync;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         frame_sync <= 2'h0;
         energy_sync <= 2'h0;
      end else begin
         frame_sync <= {frame_sync[0], wake_frame_event};
         energy_sync <= {energy_sync[0], energy_event};
      end
   end
   logic frame_ev;
   logic energy_ev;
   assign frame_ev = frame_sync[1];
   assign energy_ev = energy_sync[1];

   // ----------------------------------------
   // access qualification
   // ----------------------------------------
   logic ready;
   logic read_seen;
   logic ctrl_wr;
   logic wake_wr;
   logic sleeping;
   assign sleeping = (power_state_select != 2'h0);
   // control writes before the first read are dropped on purpose
   assign ctrl_wr = bus.wr && read_seen && ready && (bus.addr == `OFS_POWER_WAKE_CONTROL); // [RULE_01] [RULE_06]
   assign wake_wr = bus.wr && (bus.addr == `OFS_BYTE_TEST) && sleeping; // [RULE_05]

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         read_seen <= 1'b0;
      end else if (wake_wr) begin
         read_seen <= 1'b0; // [RULE_01]
      end else if (bus.rd) begin
         read_seen <= 1'b1;
      end
   end

   // ready settles a fixed time after reset and after each wake
   logic [4:0] settle;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         settle <= 5'h0;
         ready <= 1'b0;
      end else if (wake_wr) begin
         settle <= 5'h0;
         ready <= 1'b0; // [RULE_18]
      end else if (sleeping) begin
         ready <= 1'b0;
      end else if (!ready) begin
         if (settle == SETTLE_LAST) begin
            ready <= 1'b1; // [RULE_18]
         end else begin
            settle <= settle + 5'h1;
         end
      end
   end

   // ----------------------------------------
   // power state
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         power_state_select <= 2'h0;
      end else if (wake_wr) begin
         power_state_select <= full_power_state; // [RULE_04] [RULE_05]
      end else if (ctrl_wr) begin
         // the reserved code is refused and leaves the state unchanged
         if (bus.wdata[`BIT_STATE_HI:`BIT_STATE_LO] != reserved_state) begin
            power_state_select <= bus.wdata[`BIT_STATE_HI:`BIT_STATE_LO]; // [RULE_03]
         end
      end
   end

   // ----------------------------------------
   // transceiver reset
   // ----------------------------------------
   logic [RST_W-1:0] rst_count;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         transceiver_reset <= 1'b0;
         rst_count <= '0;
      end else if (transceiver_reset) begin
         if (rst_count == RST_LAST) begin
            transceiver_reset <= 1'b0; // [RULE_07]
         end else begin
            rst_count <= rst_count + 1'b1;
         end
      end else if (ctrl_wr && bus.wdata[`BIT_XCVR_RST]) begin // [RULE_08]
         transceiver_reset <= 1'b1; // [RULE_07]
         rst_count <= '0;
      end
   end

   // ----------------------------------------
   // configuration bits
   // ----------------------------------------
   logic frame_en;
   logic energy_en;
   logic drv_push_pull;
   logic pulse_sel;
   logic polarity;
   logic out_en;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         frame_en <= 1'b0;
         energy_en <= 1'b0;
         drv_push_pull <= 1'b0;
         pulse_sel <= 1'b0;
         polarity <= 1'b0;
         out_en <= 1'b0;
      end else if (ctrl_wr) begin
         frame_en <= bus.wdata[`BIT_WAKE_FRAME_EN];
         energy_en <= bus.wdata[`BIT_ENERGY_EN];
         drv_push_pull <= bus.wdata[`BIT_DRIVER_TYPE];
         pulse_sel <= bus.wdata[`BIT_PULSE_SEL];
         polarity <= bus.wdata[`BIT_POLARITY];
         out_en <= bus.wdata[`BIT_OUT_EN];
      end
   end

   // ----------------------------------------
   // wake cause
   // ----------------------------------------
   // bit 0 energy, bit 1 frame; both set reads as multiple events
   logic [1:0] cause;
   logic [1:0] src;
   logic [1:0] clr;
   assign src = {frame_en & frame_ev, energy_en & energy_ev}; // [RULE_09] [RULE_10]
   // a clear only lands while ready and the source has gone quiet
   assign clr = (ctrl_wr && !sleeping) ?
      (bus.wdata[`BIT_CAUSE_HI:`BIT_CAUSE_LO] & ~src) : 2'h0; // [RULE_13]
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cause <= 2'h0;
      end else begin
         cause <= src | (cause & ~clr); // [RULE_12] [RULE_13]
      end
   end

   // ----------------------------------------
   // wake output and interrupt
   // ----------------------------------------
   logic active;
   logic pulse_done;
   logic [PULSE_W-1:0] pulse_count;
   logic wake_active;
   // dropping either the cause or its enable releases the output
   assign active = |(cause & {frame_en, energy_en}); // [RULE_15]
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pulse_count <= '0;
         pulse_done <= 1'b0;
      end else if (!active) begin
         pulse_count <= '0;
         pulse_done <= 1'b0;
      end else if (pulse_sel && !pulse_done) begin
         if (pulse_count == PULSE_LAST) begin
            pulse_done <= 1'b1; // [RULE_14]
         end else begin
            pulse_count <= pulse_count + 1'b1;
         end
      end
   end
   assign wake_active = active && !(pulse_sel && pulse_done); // [RULE_14]

   logic next_o;
   logic next_oe;
   always_comb begin
      next_o = 1'b0;
      next_oe = 1'b0;
      if (!drv_push_pull) begin
         next_oe = out_en && wake_active; // [RULE_11] [RULE_17]
      end else begin
         next_oe = 1'b1;
         next_o = (out_en && wake_active) ? polarity : !polarity; // [RULE_16]
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bus.wake_output_o <= 1'b0;
         bus.wake_output_oe <= 1'b0;
         bus.wake_interrupt <= 1'b0;
      end else begin
         bus.wake_output_o <= next_o;
         bus.wake_output_oe <= next_oe;
         bus.wake_interrupt <= active; // [RULE_09] [RULE_10] [RULE_17]
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   // readable in every state, ready or not
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bus.rdata <= 32'h0;
      end else if (bus.rd && bus.addr == `OFS_POWER_WAKE_CONTROL) begin // [RULE_02]
         bus.rdata <= {18'h0, power_state_select, 1'b0, transceiver_reset, frame_en,
            energy_en, 1'b0, drv_push_pull, cause, pulse_sel, polarity, out_en, ready};
      end else begin
         bus.rdata <= 32'h0;
      end
   end
endmodule
`default_nettype wire

/* rtl/pwr_wake_host.sv */
// host end: register port master for the power and wake control register
`timescale 1ns/1ps
`default_nettype none
`include "pwr_wake_defines.svh"
module pwr_wake_host
   import pwr_wake_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // register port
   pwr_wake_if.host bus,
   // user requests
   input wire logic req_write,
   input wire logic req_wake,
   input wire logic [31:0] req_data,
   // user answers
   output logic busy,
   output logic done,
   output logic [31:0] status,
   output logic device_ready
);
   typedef enum logic [2:0] {idle, poll_issue, poll_gap, poll_wait, wr_go, wake_go} host_state_t;
   host_state_t state;
   logic pending_write;
   logic [31:0] pending_data;

   // every control write is preceded by a poll until ready reads one
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= idle;
         pending_write <= 1'b0;
         pending_data <= 32'h0;
         busy <= 1'b0;
         done <= 1'b0;
         status <= 32'h0;
         device_ready <= 1'b0;
         bus.addr <= 8'h0;
         bus.wdata <= 32'h0;
         bus.wr <= 1'b0;
         bus.rd <= 1'b0;
      end else begin
         done <= 1'b0;
         bus.wr <= 1'b0;
         bus.rd <= 1'b0;
         unique case (state)
            idle: begin
               busy <= 1'b0;
               if (req_wake) begin
                  bus.addr <= `OFS_BYTE_TEST; // [RULE_06]
                  bus.wdata <= 32'h0;
                  bus.wr <= 1'b1;
                  busy <= 1'b1;
                  state <= wake_go;
               end else if (req_write) begin
                  pending_write <= 1'b1;
                  pending_data <= req_data;
                  busy <= 1'b1;
                  state <= poll_issue;
               end
            end
            wake_go: begin
               device_ready <= 1'b0;
               pending_write <= 1'b0;
               state <= poll_issue;
            end
            poll_issue: begin
               bus.addr <= `OFS_POWER_WAKE_CONTROL; // [RULE_19]
               bus.rd <= 1'b1; // [RULE_01]
               state <= poll_gap;
            end
            poll_gap: begin
               // read data is registered: it stands only in the cycle after the strobe
               state <= poll_wait;
            end
            poll_wait: begin
               status <= bus.rdata;
               device_ready <= bus.rdata[`BIT_READY];
               if (!bus.rdata[`BIT_READY]) begin
                  // a sleeping device never turns ready, so a wake may break the poll
                  if (req_wake) begin
                     bus.addr <= `OFS_BYTE_TEST; // [RULE_06]
                     bus.wdata <= 32'h0;
                     bus.wr <= 1'b1;
                     state <= wake_go;
                  end else begin
                     state <= poll_issue; // [RULE_18]
                  end
               end else if (pending_write) begin
                  bus.wdata <= pending_data;
                  bus.wr <= 1'b1;
                  pending_write <= 1'b0;
                  state <= wr_go;
               end else begin
                  done <= 1'b1;
                  state <= idle;
               end
            end
            wr_go: begin
               done <= 1'b1;
               state <= idle;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* verification/pwr_wake_sva.sv */
// assertions on the register port and wake pins between host and device
`timescale 1ns/1ps
`default_nettype none
`include "pwr_wake_defines.svh"
module pwr_wake_sva (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // link signals
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic [31:0] rdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic wake_output_o,
   input wire logic wake_output_oe,
   input wire logic wake_interrupt
);
   logic rd_d;
   logic read_seen;
   logic ready_seen;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // ---------------------------------------------
   // helper state
   // ---------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rd_d <= 1'b0;
      end else begin
         rd_d <= rd && addr == `OFS_POWER_WAKE_CONTROL;
      end
   end
   // a wake write wipes the read history, as after reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         read_seen <= 1'b0;
      end else if (rd && addr == `OFS_POWER_WAKE_CONTROL) begin
         read_seen <= 1'b1;
      end else if (wr && addr == `OFS_BYTE_TEST) begin
         read_seen <= 1'b0;
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ready_seen <= 1'b0;
      end else if (rd_d) begin
         ready_seen <= rdata[`BIT_READY];
      end
   end
   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   a_read_before_write: assert property (
      wr && addr == `OFS_POWER_WAKE_CONTROL |-> read_seen)
      else $error("control write without prior read");
   a_notready_wr_wake: assert property (
      wr && !ready_seen |-> addr == `OFS_BYTE_TEST)
      else $error("write to other address while not ready");
   a_notready_rd_ok: assert property (
      rd && !ready_seen |-> addr == `OFS_POWER_WAKE_CONTROL || addr == `OFS_HW_CONFIG)
      else $error("forbidden read while not ready");
   a_reserved_zero: assert property (
      rd_d |-> rdata[31:14] == 18'h0 && !rdata[11] && !rdata[7])
      else $error("reserved bits not zero");
   a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
      else $error("read data without read");
   a_cause_irq: assert property (
      rd_d && ((rdata[5] && rdata[9]) || (rdata[4] && rdata[8])) |-> ##[0:2] wake_interrupt)
      else $error("enabled cause without interrupt");
   a_irq_no_cause: assert property (
      rd_d && rdata[5:4] == 2'b00 |-> !wake_interrupt)
      else $error("interrupt with no cause");
   a_od_never_high: assert property (
      rd_d && !rdata[6] |-> !(wake_output_oe && wake_output_o))
      else $error("open drain driven high");
   a_pp_idle_level: assert property (
      rd_d && rdata[6] && rdata[1] && rdata[5:4] == 2'b00
      |-> wake_output_oe && wake_output_o == !rdata[2])
      else $error("push-pull idle level wrong");
   a_od_disabled: assert property (
      rd_d && !rdata[6] && !rdata[1] |-> !wake_output_oe)
      else $error("disabled open drain driven");
   c_wake_irq: cover property ($rose(wake_interrupt));
   c_wake_write: cover property (wr && addr == `OFS_BYTE_TEST);
   c_sleep_read: cover property (rd_d && rdata[13:12] != 2'b00);
endmodule
`default_nettype wire

/* verification/power_mgmt_wake_control_bench.sv */
// self-checking bench joining host and device ends of the wake control link
`timescale 1ns/1ps
`default_nettype none
`include "pwr_wake_defines.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module power_mgmt_wake_control_bench
   import pwr_wake_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic wake_frame_event = 1'b0;
   logic energy_event = 1'b0;
   logic req_write = 1'b0;
   logic req_wake = 1'b0;
   logic [31:0] req_data = 32'h0;
   logic busy, done, device_ready, transceiver_reset, a, hit;
   logic [31:0] status, d, r;
   logic [31:0] seed = 32'h24;
   logic [1:0] power_state_select, ev, ex;
   int n_errors = 0;
   int comparisons = 0;
   int rst_len = 0;
   int k;
   pwr_wake_if bus_if();
   // pull-up on the wake wire, so a released open drain reads high
   wire logic pin = bus_if.wake_output_oe ? bus_if.wake_output_o : 1'b1;
   pwr_wake_device u_pwr_wake_device (.core_clk(core_clk), .rst(rst), .bus(bus_if),
      .wake_frame_event(wake_frame_event), .energy_event(energy_event),
      .transceiver_reset(transceiver_reset), .power_state_select(power_state_select));
   pwr_wake_host u_pwr_wake_host (.core_clk(core_clk), .rst(rst), .bus(bus_if),
      .req_write(req_write), .req_wake(req_wake), .req_data(req_data), .busy(busy),
      .done(done), .status(status), .device_ready(device_ready));
   pwr_wake_sva u_pwr_wake_sva (.core_clk(core_clk), .rst(rst), .addr(bus_if.addr),
      .wdata(bus_if.wdata), .rdata(bus_if.rdata), .wr(bus_if.wr), .rd(bus_if.rd),
      .wake_output_o(bus_if.wake_output_o), .wake_output_oe(bus_if.wake_output_oe),
      .wake_interrupt(bus_if.wake_interrupt));
   initial begin
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (transceiver_reset === 1'b1) rst_len++;
   end
   function automatic logic [31:0] xorshift();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic act_lvl(input logic [31:0] c);
      return c[6] ? c[2] : 1'b0;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask
   task automatic op(input logic wake, input logic [31:0] dv);
      int i;
      req_write = !wake;
      req_wake = wake;
      req_data = dv;
      cyc(1);
      // a polling host takes a wake only at its read-back; hold it until the write
      for (i = 0; i < 50 && wake && bus_if.wr !== 1'b1; i++) cyc(1);
      req_write = 1'b0;
      req_wake = 1'b0;
      `CHK("busy_set", 1'b1, busy)
      for (i = 0; i < 3000 && done !== 1'b1; i++) cyc(1);
      `CHK("done", 1'b1, done)
      cyc(1);
      `CHK("busy_clr", 1'b0, busy)
   endtask
   task automatic summarize();
      if (n_errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge core_clk);
      n_errors++;
      summarize();
   end
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      cyc(4);
      rst = 1'b0;
      `CHK("st_rst", full_power_state, power_state_select)
      `CHK("irq_rst", 1'b0, bus_if.wake_interrupt)
      for (k = 0; k < 8; k++) begin
         r = xorshift();
         ev = 2'(k % 3 + 1);
         d = {22'h0, r[0] | k == 0, r[1] | k == 0, 1'b0, r[2], 3'h0, r[3], r[4] | k == 0, 1'b0};
         ex = {ev[1] & d[9], ev[0] & d[8]};
         op(1'b0, d);
         `CHK("ready", 1'b1, device_ready)
         {wake_frame_event, energy_event} = ev;
         cyc(4);
         {wake_frame_event, energy_event} = 2'b00;
         cyc(6);
         a = d[1] && ex != 2'b00;
         `CHK("irq", |ex, bus_if.wake_interrupt)
         hit = bus_if.wake_output_oe && bus_if.wake_output_o === act_lvl(d);
         if (d[1]) `CHK("pin", a ? act_lvl(d) : !act_lvl(d), pin)
         else `CHK("pin_off", 1'b0, hit)
         op(1'b0, d | 32'h30);
         `CHK("cause", ex, status[5:4])
         cyc(3);
         `CHK("irq_clr", 1'b0, bus_if.wake_interrupt)
         hit = bus_if.wake_output_oe && bus_if.wake_output_o === act_lvl(d);
         `CHK("pin_clr", 1'b0, hit)
      end
      // pulse mode: the 50 ms pulse is far too long to watch end to end
      op(1'b0, 32'h24E);
      wake_frame_event = 1'b1;
      cyc(4);
      wake_frame_event = 1'b0;
      cyc(1000);
      `CHK("pulse", 1'b1, pin)
      op(1'b0, 32'h27E);
      cyc(3);
      `CHK("pulse_clr", 1'b0, pin)
      rst_len = 0;
      op(1'b0, 32'h400);
      cyc(100);
      op(1'b0, 32'h400);
      `CHK("xrst_bit", 1'b1, status[10])
      cyc(2600);
      `CHK("xrst_len", `XCVR_RST_CYCLES, rst_len)
      `CHK("xrst_end", 1'b0, transceiver_reset)
      for (k = 1; k < 4; k++) begin
         d = 32'(k) << 12;
         op(1'b0, d);
         cyc(2);
         `CHK("state", 2'(k % 3), power_state_select)
         if (k != 3) begin
            // a write request leaves the host polling the sleeping device
            req_write = 1'b1;
            cyc(1);
            req_write = 1'b0;
            cyc(12);
            `CHK("sleep_read", 2'(k), status[13:12])
            `CHK("sleep_ready", 1'b0, device_ready)
            op(1'b1, 32'h0);
            `CHK("woke", full_power_state, power_state_select)
            `CHK("ready_wake", 1'b1, device_ready)
            `CHK("state_clr", 2'h0, status[13:12])
         end
      end
      summarize();
   end
endmodule
`default_nettype wire
